// >>> dsrc_top.sv
`default_nettype none
module dsrc_top (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // serial link
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 config_serial_in,
  output logic                      serial_out_first,
  output logic                      serial_out_first_oe,
  output logic                      serial_out_second,
  output logic                      serial_out_second_oe,
  // calibration request pin
  input  wire logic                 cal_req,
  // converter core
  input  wire logic [13:0]          conv_code_a,
  input  wire logic [13:0]          conv_code_b,
  output logic                      hold_en,
  output logic                      conv_start,
  output logic                      cal_short,
  output dsrc_pkg::dsrc_ctrl_t      ctrl,
  // status
  output logic                      cal_done,
  output logic                      cal_inaccurate,
  output logic                      result_corrupt,
  output logic                      offset_stale
);
  import dsrc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // frame timing
  dsrc_frame_t frm;
  logic        at_conv;
  logic        at_chain;
  logic        at_commit;
  logic        cfg_fall;

  dsrc_frame u_frame (
    .clk  (clk),
    .rst  (rst),
    .cs_n (cs_n),
    .sclk (sclk),
    .frm  (frm)
  );

  assign at_conv   = frm.fall && frm.cnt == EDGE_CONV;
  assign at_chain  = frm.fall && frm.cnt == EDGE_CHAIN;
  assign at_commit = frm.fall && frm.cnt == EDGE_COMMIT;
  assign cfg_fall  = frm.fall && frm.cnt <= EDGE_CFG_LAST;

  ////////////////////////////////////////////////////////////////////////////
  // sequence state
  dsrc_state_t st_ff;
  dsrc_state_t nxt_st;
  logic        hold_ff;
  logic        nxt_hold;
  logic        oe_ff;
  logic        nxt_oe;
  logic        cal_frame_ff;
  logic        nxt_cal_frame;
  logic        start_ff;
  logic        nxt_start;

  always_comb begin
    nxt_st        = st_ff;
    nxt_hold      = hold_ff;
    nxt_oe        = oe_ff;
    nxt_cal_frame = cal_frame_ff;
    nxt_start     = frm.cs_fall;
    if (frm.cs_rise) begin
      nxt_st   = ST_IDLE;
      nxt_hold = 1'b0;
      nxt_oe   = 1'b0;
    end else if (frm.cs_fall) begin
      nxt_st        = ST_CONV;
      nxt_hold      = 1'b1;
      nxt_oe        = 1'b0;
      nxt_cal_frame = cal_req | ctrl.cal;
    end else begin
      unique case (st_ff)
        ST_CONV: begin
          if (at_conv) begin
            nxt_st   = ST_SHIFT;
            nxt_hold = 1'b0;
            nxt_oe   = 1'b1;
          end
        end
        ST_SHIFT: begin
          if (at_chain) begin
            nxt_st = ST_DONE;
            nxt_oe = 1'b0;
          end
        end
        ST_IDLE, ST_DONE: begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff        <= ST_IDLE;
      hold_ff      <= 1'b0;
      oe_ff        <= 1'b0;
      cal_frame_ff <= 1'b0;
      start_ff     <= 1'b0;
    end else begin
      st_ff        <= nxt_st;
      hold_ff      <= nxt_hold;
      oe_ff        <= nxt_oe;
      cal_frame_ff <= nxt_cal_frame;
      start_ff     <= nxt_start;
    end
  end

  assign hold_en              = hold_ff;
  assign conv_start           = start_ff;
  assign cal_short            = cal_frame_ff && st_ff == ST_CONV;
  assign serial_out_first_oe  = oe_ff;
  assign serial_out_second_oe = oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // configuration shift and registers
  logic [15:0] cfg_sr_ff;
  logic [15:0] nxt_cfg_sr;
  dsrc_ctrl_t  ctrl_ff;
  dsrc_ctrl_t  nxt_ctrl;
  logic [11:0] ofs_a_ff;
  logic [11:0] ofs_b_ff;
  logic [11:0] nxt_ofs_a;
  logic [11:0] nxt_ofs_b;
  logic [3:0]  ofs_gain_ff;
  logic [3:0]  nxt_ofs_gain;
  logic [11:0] cal_a;
  logic [11:0] cal_b;

  // clamp a raw code into the correctable window
  function automatic logic [11:0] clamp_ofs(input logic [13:0] code);
    logic signed [13:0] s;
    s = $signed(code);
    if (s > $signed(OFS_LIMIT)) begin
      clamp_ofs = OFS_LIMIT[11:0];
    end else if (s < -$signed(OFS_LIMIT)) begin
      clamp_ofs = 12'(-$signed(OFS_LIMIT));
    end else begin
      clamp_ofs = code[11:0];
    end
  endfunction

  assign cal_a = clamp_ofs(conv_code_a);
  assign cal_b = clamp_ofs(conv_code_b);

  always_comb begin
    nxt_cfg_sr   = cfg_sr_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_ofs_a    = ofs_a_ff;
    nxt_ofs_b    = ofs_b_ff;
    nxt_ofs_gain = ofs_gain_ff;
    if (cfg_fall) begin
      nxt_cfg_sr = {cfg_sr_ff[14:0], config_serial_in};
    end
    if (at_commit) begin
      unique case (cfg_sr_ff[15:12])
        SEL_CTRL: begin
          nxt_ctrl = dsrc_ctrl_t'(cfg_sr_ff[11:0]);
        end
        SEL_OFS_A: begin
          nxt_ofs_a    = cfg_sr_ff[11:0];
          nxt_ofs_gain = ctrl_ff.gain;
        end
        SEL_OFS_B: begin
          nxt_ofs_b    = cfg_sr_ff[11:0];
          nxt_ofs_gain = ctrl_ff.gain;
        end
        default: begin
        end
      endcase
    end
    if (at_conv && cal_frame_ff) begin
      nxt_ofs_a    = cal_a;
      nxt_ofs_b    = cal_b;
      nxt_ofs_gain = ctrl_ff.gain;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_sr_ff   <= 16'h0000;
      ctrl_ff     <= dsrc_ctrl_t'(CTRL_RST);
      ofs_a_ff    <= OFS_RST;
      ofs_b_ff    <= OFS_RST;
      ofs_gain_ff <= 4'h0;
    end else begin
      cfg_sr_ff   <= nxt_cfg_sr;
      ctrl_ff     <= nxt_ctrl;
      ofs_a_ff    <= nxt_ofs_a;
      ofs_b_ff    <= nxt_ofs_b;
      ofs_gain_ff <= nxt_ofs_gain;
    end
  end

  assign ctrl         = ctrl_ff;
  // old offset keeps being removed after a gain change
  assign offset_stale = ofs_gain_ff != ctrl_ff.gain;

  ////////////////////////////////////////////////////////////////////////////
  // result correction and output words
  logic [13:0] res_a;
  logic [13:0] res_b;
  logic [13:0] sel_word;
  logic [27:0] ld_a;
  logic [27:0] ld_b;
  logic        shift_en;

  // subtract the stored offset and saturate to the code range
  function automatic logic [13:0] correct(input logic [13:0] code, input logic [11:0] ofs);
    logic signed [14:0] d;
    d = $signed({code[13], code}) - $signed({{3{ofs[11]}}, ofs});
    if (d > 15'sh1fff) begin
      correct = 14'h1fff;
    end else if (d < -15'sh2000) begin
      correct = 14'h2000;
    end else begin
      correct = d[13:0];
    end
  endfunction

  assign res_a = cal_frame_ff ? conv_code_a : correct(conv_code_a, ofs_a_ff);
  assign res_b = cal_frame_ff ? conv_code_b : correct(conv_code_b, ofs_b_ff);

  always_comb begin
    unique case (ctrl_ff.rd_sel)
      SEL_RESULT: sel_word = res_a;
      SEL_CTRL:   sel_word = {2'h0, ctrl_ff};
      SEL_OFS_A:  sel_word = {2'h0, ofs_a_ff};
      SEL_OFS_B:  sel_word = {2'h0, ofs_b_ff};
      default:    sel_word = 14'h0000;
    endcase
  end

  // line a: selected word first, line b: own word first; the other converter's after it
  assign ld_a     = {sel_word, res_b};
  assign ld_b     = {res_b, res_a};
  assign shift_en = frm.fall && st_ff == ST_SHIFT;

  dsrc_shift #(.W(28)) u_shift_a (
    .clk      (clk),
    .rst      (rst),
    .load     (at_conv),
    .load_val (ld_a),
    .shift    (shift_en),
    .bit_out  (serial_out_first)
  );

  dsrc_shift #(.W(28)) u_shift_b (
    .clk      (clk),
    .rst      (rst),
    .load     (at_conv),
    .load_val (ld_b),
    .shift    (shift_en),
    .bit_out  (serial_out_second)
  );

  ////////////////////////////////////////////////////////////////////////////
  // calibration status
  logic [7:0] req_age_ff;
  logic [7:0] nxt_req_age;
  logic       req_prev_ff;
  logic       inacc_ff;
  logic       nxt_inacc;
  logic       corrupt_ff;
  logic       nxt_corrupt;
  logic       done_ff;
  logic       nxt_done;

  always_comb begin
    nxt_req_age = req_age_ff;
    if (!cal_req) begin
      nxt_req_age = 8'h00;
    end else if (req_age_ff != 8'hff) begin
      nxt_req_age = req_age_ff + 8'h01;
    end
    nxt_inacc   = inacc_ff;
    nxt_corrupt = corrupt_ff;
    if (frm.cs_fall) begin
      // request not up long enough before the sample instant
      nxt_inacc   = cal_req && req_age_ff < SETUP_CYC;
      nxt_corrupt = 1'b0;
    end
    // mid-conversion request or control-bit calibration spoils this result
    if (st_ff == ST_CONV && cal_req && !req_prev_ff) begin
      nxt_corrupt = 1'b1;
    end
    if (at_commit && cfg_sr_ff[15:12] == SEL_CTRL && cfg_sr_ff[CAL_BIT]) begin
      nxt_corrupt = 1'b1;
    end
    nxt_done = at_conv && cal_frame_ff;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      req_age_ff  <= 8'h00;
      req_prev_ff <= 1'b0;
      inacc_ff    <= 1'b0;
      corrupt_ff  <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      req_age_ff  <= nxt_req_age;
      req_prev_ff <= cal_req;
      inacc_ff    <= nxt_inacc;
      corrupt_ff  <= nxt_corrupt;
      done_ff     <= nxt_done;
    end
  end

  assign cal_done       = done_ff;
  assign cal_inaccurate = inacc_ff;
  assign result_corrupt = corrupt_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_hold_on_fall: assert property (frm.cs_fall |=> hold_en && conv_start)
    else $error("no hold after cs fall");
  chk_quiet_conv: assert property (st_ff == ST_CONV |-> !serial_out_first_oe
    && !serial_out_second_oe)
    else $error("line driven during conversion");
  chk_drive_at_19: assert property (at_conv && !frm.cs_rise |=> serial_out_first_oe
    && serial_out_second_oe && !hold_en)
    else $error("lines not driven after fall 19");
  chk_msb_launch: assert property (at_conv |=> serial_out_second == $past(res_b[13]))
    else $error("msb not launched on fall 19");
  chk_bit_steady: assert property (st_ff == ST_SHIFT && !frm.fall && !at_conv
    |=> $stable(serial_out_first))
    else $error("bit moved without sclk fall");
  chk_release_rise: assert property (frm.cs_rise |=> !serial_out_first_oe
    && !serial_out_second_oe)
    else $error("line driven after cs rise");
  chk_chain_end: assert property (at_chain |=> !serial_out_first_oe [*2])
    else $error("line driven after fall 47");
  chk_cal_each: assert property (frm.cs_fall && (cal_req || ctrl.cal) |=> cal_frame_ff)
    else $error("calibration not started");
  chk_cal_store: assert property (at_conv && cal_frame_ff |=> cal_done
    && ofs_a_ff == $past(cal_a))
    else $error("offset not stored at fall 19");
  chk_ofs_range: assert property (cal_done |-> $signed(ofs_b_ff) <= $signed(OFS_LIMIT[11:0])
    && $signed(ofs_b_ff) >= -$signed(OFS_LIMIT[11:0]))
    else $error("calibrated offset out of range");
endmodule
`default_nettype wire

// >>> dsrc_pkg.sv
`default_nettype none
package dsrc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RES_W         = 14;
  localparam int unsigned REG_W         = 12;
  localparam int unsigned CNT_W         = 6;
  // edge numbers counted from the cs fall
  localparam logic [5:0]  EDGE_CFG_LAST = 6'h10;
  localparam logic [5:0]  EDGE_COMMIT   = 6'h11;
  localparam logic [5:0]  EDGE_CONV     = 6'h13;
  localparam logic [5:0]  EDGE_CHAIN    = 6'h2f;
  localparam logic [5:0]  EDGE_MAX      = 6'h3f;
  // write targets and read-select codes
  localparam logic [3:0]  SEL_RESULT    = 4'h0;
  localparam logic [3:0]  SEL_CTRL      = 4'h1;
  localparam logic [3:0]  SEL_OFS_A     = 4'h2;
  localparam logic [3:0]  SEL_OFS_B     = 4'h3;
  // control word fields
  localparam int unsigned RD_LSB        = 8;
  localparam int unsigned CAL_BIT       = 7;
  localparam int unsigned PD_LSB        = 4;
  localparam int unsigned GAIN_LSB      = 0;
  localparam logic [11:0] CTRL_RST      = 12'h000;
  localparam logic [11:0] OFS_RST       = 12'h000;
  localparam logic [13:0] OFS_LIMIT     = 14'h01f4;
  // request setup before cs fall; plain default, tune for the part
  localparam int unsigned SETUP_NS      = 50;
  localparam int unsigned SETUP_CYC_I   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETUP_CYC     = (SETUP_CYC_I < 1) ? 8'h01 : 8'(SETUP_CYC_I);

  typedef struct packed {
    logic [3:0] rd_sel;
    logic       cal;
    logic [2:0] pd;
    logic [3:0] gain;
  } dsrc_ctrl_t;

  typedef struct packed {
    logic       cs_fall;
    logic       cs_rise;
    logic       fall;
    logic [5:0] cnt;
  } dsrc_frame_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_SHIFT = 2'b11,
    ST_DONE  = 2'b10
  } dsrc_state_t;
endpackage
`default_nettype wire

// >>> dsrc_frame.sv
`default_nettype none
module dsrc_frame (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           rst,
  // serial frame pins
  input  wire logic           cs_n,
  input  wire logic           sclk,
  // frame events
  output dsrc_pkg::dsrc_frame_t frm
);
  import dsrc_pkg::*;

  logic       cs_prev_ff;
  logic       sclk_prev_ff;
  logic [5:0] cnt_ff;
  logic       nxt_cs_prev;
  logic       nxt_sclk_prev;
  logic [5:0] nxt_cnt;
  logic       cs_fall;
  logic       fall;

  always_comb begin
    cs_fall       = cs_prev_ff & ~cs_n;
    // a fall together with cs fall is not counted
    fall          = sclk_prev_ff & ~sclk & ~cs_n & ~cs_fall;
    nxt_cs_prev   = cs_n;
    nxt_sclk_prev = sclk;
    nxt_cnt       = cnt_ff;
    if (cs_n) begin
      nxt_cnt = 6'h00;
    end else if (fall && cnt_ff != EDGE_MAX) begin
      nxt_cnt = cnt_ff + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_prev_ff   <= 1'b1;
      sclk_prev_ff <= 1'b0;
      cnt_ff       <= 6'h00;
    end else begin
      cs_prev_ff   <= nxt_cs_prev;
      sclk_prev_ff <= nxt_sclk_prev;
      cnt_ff       <= nxt_cnt;
    end
  end

  // cnt carries the number of the fall seen in this cycle
  assign frm = '{cs_fall: cs_fall, cs_rise: ~cs_prev_ff & cs_n, fall: fall, cnt: nxt_cnt};

  chk_skip_first: assert property (@(posedge clk) disable iff (rst)
    cs_fall |=> cnt_ff == 6'h00)
    else $error("fall at cs fall was counted");
endmodule
`default_nettype wire

// >>> dsrc_shift.sv
`default_nettype none
module dsrc_shift #(
  parameter int unsigned W = 28
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         shift,
  // serial bit
  output logic              bit_out
);
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (load) begin
      nxt_q = load_val;
    end else if (shift) begin
      nxt_q = {q_ff[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign bit_out = q_ff[W-1];
endmodule
`default_nettype wire

// >>> dsrc_host_model.sv
`default_nettype none
module dsrc_host_model (
  // clock
  input  wire logic        clk,
  // command
  input  wire logic        go,
  input  wire logic [5:0]  nfalls,
  input  wire logic        coin,
  input  wire logic [15:0] cfg,
  input  wire logic        rise_cap,
  // serial pins
  output logic             cs_n,
  output logic             sclk,
  output logic             din,
  input  wire logic        out_a,
  input  wire logic        oe_a,
  input  wire logic        out_b,
  input  wire logic        oe_b,
  // capture, indexed by fall number
  output logic             busy,
  output logic [63:0]      rx_a,
  output logic [63:0]      rx_b,
  output logic [63:0]      oe_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 3;
  // no pull on the lines: a released line shows the inverse of its last bit
  wire logic line_a = oe_a ? out_a : ~out_a;
  wire logic line_b = oe_b ? out_b : ~out_b;
  ////////////////////////////////////////////////////////////////////////////
  // one process owns every pin so each has a single driver
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy    <= 1'b1;
        rx_a    <= '0;
        rx_b    <= '0;
        oe_seen <= '0;
        cs_n    <= 1'b0;
        sclk    <= ~coin; // a fall together with cs fall must not count
        repeat (HALF) @(posedge clk);
        sclk <= 1'b1;
        din  <= cfg[15]; // target then data, msb first
        for (int k = 1; k <= int'(nfalls); k++) begin
          repeat (HALF) @(posedge clk);
          sclk       <= 1'b0;
          oe_seen[k] <= oe_a | oe_b;
          if (!rise_cap) begin
            // bit launched one fall earlier, taken on this fall
            rx_a[k] <= line_a;
            rx_b[k] <= line_b;
          end
          repeat (HALF) @(posedge clk);
          sclk <= 1'b1;
          din  <= (k < 16) ? cfg[15-k] : ~din;
          if (rise_cap) begin
            // slow host: bit of fall k taken on the rising edge after it
            rx_a[k+1] <= line_a;
            rx_b[k+1] <= line_b;
          end
        end
        // clock stands high between frames
        cs_n <= 1'b1;
        repeat (2) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  logic        clk, rst, cs_n, sclk, din, cal_req, go, coin, busy, rise_cap;
  logic        out_a, oe_a, out_b, oe_b, hold_en, conv_start, cal_short;
  logic        cal_done, cal_inacc, res_bad, ofs_stale;
  logic [13:0] code_a, code_b, trim;
  dsrc_ctrl_t  ctrl;
  logic [5:0]  nfalls;
  logic [15:0] cfg;
  logic [63:0] rx_a, rx_b, oe_seen;
  logic [11:0] ctrl_m, ofs_a_m, ofs_b_m;
  logic [3:0]  gain_m;
  logic [31:0] seed;
  int          error_cnt, checks_done, cyc, n_done, n_start, n_short;

  dsrc_top i_dsrc_top (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .config_serial_in(din), .serial_out_first(out_a), .serial_out_first_oe(oe_a),
    .serial_out_second(out_b), .serial_out_second_oe(oe_b), .cal_req(cal_req),
    .conv_code_a(code_a), .conv_code_b(code_b), .hold_en(hold_en),
    .conv_start(conv_start), .cal_short(cal_short), .ctrl(ctrl), .cal_done(cal_done),
    .cal_inaccurate(cal_inacc), .result_corrupt(res_bad), .offset_stale(ofs_stale));
  dsrc_host_model i_dsrc_host_model (.clk(clk), .go(go), .nfalls(nfalls), .coin(coin),
    .cfg(cfg), .rise_cap(rise_cap), .cs_n(cs_n), .sclk(sclk), .din(din), .out_a(out_a),
    .oe_a(oe_a), .out_b(out_b), .oe_b(oe_b), .busy(busy), .rx_a(rx_a), .rx_b(rx_b),
    .oe_seen(oe_seen));

  initial clk = 1'b0;
  always #12.5ns clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // longest run is well under this; a hang ends here
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (conv_start === 1'b1 && hold_en === 1'b1) n_start = n_start + 1;
    if (cal_done === 1'b1) n_done = n_done + 1;
    if (cal_short === 1'b1) n_short = n_short + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [13:0] sub_sat(logic [13:0] raw, logic [11:0] ofs);
    int v;
    v = int'($signed(raw)) - int'($signed(ofs));
    if (v > 8191) v = 8191;
    if (v < -8192) v = -8192;
    return v[13:0];
  endfunction

  function automatic logic [11:0] clamp(logic [13:0] raw);
    int v;
    v = int'($signed(raw));
    if (v > 500) v = 500;
    if (v < -500) v = -500;
    return v[11:0];
  endfunction

  task automatic cmp_vec(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // req: 0 none, 1 raised with the cs fall, 2 raised mid conversion
  task automatic frame(input int n, input logic [15:0] c, input logic cn, input logic chk,
                       input int req);
    logic [13:0] ca, cb, ra, rb, wa;
    logic [63:0] ea, eb, eo, m;
    logic        cal;
    ca  = 14'(rnd());
    cb  = 14'(rnd());
    cal = cal_req | ctrl_m[CAL_BIT] | (req == 1);
    ra  = cal ? ca : sub_sat(ca, ofs_a_m); // offset removed after calibration
    rb  = cal ? cb : sub_sat(cb, ofs_b_m);
    case (ctrl_m[11:8])
      SEL_RESULT: wa = ra;
      SEL_CTRL:   wa = {2'h0, ctrl_m};
      SEL_OFS_A:  wa = {2'h0, ofs_a_m};
      SEL_OFS_B:  wa = {2'h0, ofs_b_m};
      default:    wa = 14'h0;
    endcase
    ea = '0;
    eb = '0;
    eo = '0;
    m  = '0;
    for (int k = 20; k <= n && k <= 47; k++) begin
      eo[k] = 1'b1;
      m[k]  = 1'b1;
      ea[k] = (k <= 33) ? wa[33-k] : rb[47-k];
      eb[k] = (k <= 33) ? rb[33-k] : ra[47-k];
    end
    if (cal) begin
      ofs_a_m = clamp(ca);
      ofs_b_m = clamp(cb);
      gain_m  = ctrl_m[3:0];
    end
    code_a  <= ca;
    code_b  <= cb;
    nfalls  <= 6'(n);
    cfg     <= c;
    coin    <= cn;
    go      <= 1'b1;
    n_done  = 0;
    n_start = 0;
    n_short = 0;
    @(posedge clk);
    go <= 1'b0;
    if (req == 1) cal_req <= 1'b1;
    repeat (10) @(posedge clk);
    if (req == 2) cal_req <= 1'b1;
    while (busy === 1'b1) @(posedge clk);
    @(posedge clk);
    if (chk) cmp_vec("line a", ea, rx_a & m);
    if (chk) cmp_vec("line b", eb, rx_b & m);
    cmp_vec("enables", eo, oe_seen);
    cmp_bit("enable after cs rise", 1'b0, oe_a | oe_b);
    cmp_bit("one start in hold", 1'b1, n_start == 1);
    cmp_bit("hold released", 1'b0, hold_en);
    cmp_vec("cal done pulses", 64'(cal), 64'(n_done));
    cmp_bit("inputs shorted", cal, n_short > 0);
    if (c[15:12] == SEL_CTRL) ctrl_m = c[11:0];
    if (c[15:12] == SEL_OFS_A || c[15:12] == SEL_OFS_B) gain_m = ctrl_m[3:0];
    if (c[15:12] == SEL_OFS_A) ofs_a_m = c[11:0];
    if (c[15:12] == SEL_OFS_B) ofs_b_m = c[11:0];
    cmp_vec("ctrl", 64'(ctrl_m), 64'(ctrl));
    cmp_bit("stale offset", ctrl_m[3:0] != gain_m, ofs_stale);
    if (req != 1)
      cmp_bit("corrupt", req == 2 || (c[15:12] == SEL_CTRL && c[CAL_BIT]), res_bad);
    if (cal_req && req != 2) cmp_bit("inaccurate", req == 1, cal_inacc);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed        = 32'hcc1e7a11;
    error_cnt   = 0;
    checks_done = 0;
    rst         = 1'b1;
    rise_cap    = 1'b0;
    go          = 1'b0;
    cal_req     = 1'b0;
    coin        = 1'b0;
    nfalls      = 6'h00;
    cfg         = 16'h0000;
    code_a      = 14'h0000;
    code_b      = 14'h0000;
    ctrl_m      = CTRL_RST;
    ofs_a_m     = OFS_RST;
    ofs_b_m     = OFS_RST;
    gain_m      = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_bit("enable after reset", 1'b0, oe_a | oe_b);
    frame(33, 16'h0000, 1'b0, 1'b1, 0);
    frame(48, 16'h0000, 1'b1, 1'b1, 0);
    frame(25, 16'h0000, 1'b0, 1'b1, 0);
    frame(12, 16'h0000, 1'b1, 1'b1, 0);
    // pin calibration: too late, then repeated, then released
    frame(33, 16'h0000, 1'b0, 1'b1, 1);
    frame(47, 16'h0000, 1'b0, 1'b1, 0);
    cal_req <= 1'b0; // lowered only between conversions
    @(posedge clk);
    frame(33, 16'h0000, 1'b0, 1'b1, 0);
    for (int s = 1; s <= 4; s++) begin
      frame(33, {SEL_CTRL, 4'(s), 8'h05}, 1'b0, 1'b0, 0);
      frame(33, 16'h0000, 1'b0, 1'b1, 0);
    end
    frame(33, {SEL_CTRL, 12'h000}, 1'b0, 1'b0, 0);
    for (int s = 0; s < 4; s++) begin
      // keep the sign, drop the next two bits
      trim = 14'(rnd());
      frame(33, {s[0] ? SEL_OFS_B : SEL_OFS_A, trim[13], trim[10:0]}, 1'b0, 1'b0, 0);
      frame(47, 16'h0000, 1'b0, 1'b1, 0);
    end
    frame(33, 16'h4fff, 1'b0, 1'b1, 0); // unused target ignored
    frame(33, 16'hf123, 1'b0, 1'b1, 0);
    // power-down bits stay zero while calibrating
    frame(33, {SEL_CTRL, 4'h0, 1'b1, 3'h0, ctrl_m[3:0]}, 1'b0, 1'b0, 0);
    frame(33, {SEL_CTRL, 8'h00, ctrl_m[3:0]}, 1'b0, 1'b1, 0);
    frame(33, 16'h0000, 1'b0, 1'b1, 0);
    frame(33, 16'h0000, 1'b0, 1'b0, 2);
    frame(33, 16'h0000, 1'b0, 1'b1, 0);
    cal_req <= 1'b0;
    @(posedge clk);
    repeat (20) begin
      // host takes bits on falls or, when slow, on rising edges
      rise_cap <= 1'(rnd());
      frame(int'(19 + rnd() % 30), {rnd() % 2 ? SEL_CTRL : SEL_RESULT, 8'h00, 4'(rnd())},
            1'(rnd()), 1'b1, 0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
